// file: hw/efs_pkg.sv
package efs_pkg;
   // ----------------------------------------
   // apb register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] EFS_CTRL_OFS = 8'h00;
   localparam logic [7:0] EFS_DLY_OFS = 8'h04;
   localparam logic [7:0] EFS_MAJ_OFS = 8'h08;
   localparam logic [7:0] EFS_MIN_OFS = 8'h0c;
   localparam logic [7:0] EFS_ADDR_OFS = 8'h10;
   localparam logic [7:0] EFS_STAT_OFS = 8'h14;
   localparam logic [7:0] EFS_TDEV_OFS = 8'h18;
   // ctrl bit positions
   localparam int EFS_CTRL_RESET_ALL = 0;
   // ----------------------------------------
   // fault vector layout
   // ----------------------------------------
   localparam int EFS_NFLT = 6;
   localparam int EFS_F_SENS_A = 0;
   localparam int EFS_F_SENS_B = 1;
   localparam int EFS_F_OVSPD = 2;
   localparam int EFS_F_REMOTE = 3;
   localparam int EFS_F_TORQUE = 4;
   localparam int EFS_F_TDEV = 5;
   // ----------------------------------------
   // reset values and timing
   // ----------------------------------------
   localparam logic [EFS_NFLT-1:0] EFS_SEL_RST = 6'h00;
   localparam logic [12:0] EFS_DLY_RST = 13'h0064;
   localparam logic [12:0] EFS_DLY_MIN = 13'h0001;
   localparam logic [12:0] EFS_DLY_MAX = 13'h1770;
   localparam logic [12:0] EFS_TDEV_RST = 13'h0064;
   localparam int EFS_CLK_HZ = 20000000;
   localparam int EFS_TICK_MS = 10;
   localparam int EFS_TICK_CYC = EFS_CLK_HZ / 1000 * EFS_TICK_MS;
   localparam logic [17:0] EFS_TICK_LAST = 18'(EFS_TICK_CYC - 1);
   // analog limits in 0.1 mA units, crank threshold in percent
   localparam logic [7:0] EFS_MA_LO = 8'h14;
   localparam logic [7:0] EFS_MA_HI = 8'hdc;
   localparam int EFS_CRANK_PCT = 5;
   localparam int EFS_SPD_W = 16;
endpackage : efs_pkg

// file: hw/efs_supervisor.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - sensor faults latch until valid reset
// - both sensor faults force minimum fuel
// - sensor below failsafe in run latches
// - stop mode suppresses sensor faults
// - sensor indicators follow their latches
// - single sensor fault: high select, nofilter
// - watchdog timeout: healthy off, outputs locked
// - analog fault after full continuous delay
// - reset spares faults still present
// - crank speed past 5% resets faults
// - reset-all acts on rising edge only
// - address error on mismatch or zero
// - comm error needs both channels faulted
// - overspeed latches instantly, flag shows it
// - overspeed latch forces minimum actuator
// - remote input outside 2-22 mA latches
// - torque input outside 2-22 mA latches
// - torque fault selects backup load source
// - torque deviation selects backup sharing
// - valid reset restores torque sharing
// - per-fault major/minor select, default off
module efs_supervisor (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] SPEED_A,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] SPEED_B,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] FAILSAFE_SPEED,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] OVERSPEED_SETPOINT,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] RATED_SPEED,
   input wire logic RUN_MODE,
   input wire logic STOP_MODE,
   input wire logic CRANKING,
   input wire logic [7:0] REMOTE_MA,
   input wire logic [7:0] TORQUE_MA,
   input wire logic TORQUE_DEV_EXCEEDED,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic SUPPLY_GOOD,
   input wire logic COMM_FAULT_A,
   input wire logic COMM_FAULT_B,
   output logic MIN_FUEL,
   output logic HIGH_SELECT,
   output logic COUPLING_FILTER_EN,
   output logic LOAD_SRC_BACKUP,
   output logic OUTPUT_LOCK,
   output logic PROCESSOR_HEALTHY_INDICATOR,
   output logic SUPPLY_GOOD_INDICATOR,
   output logic SENSOR_A_FAILED_INDICATOR,
   output logic SENSOR_B_FAILED_INDICATOR,
   output logic ADDRESS_ERROR_INDICATOR,
   output logic COMM_ERROR_INDICATOR,
   output logic OVERSPEED_LATCHED_FLAG,
   output logic MAJOR_ALARM,
   output logic MINOR_ALARM
);
   import efs_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [EFS_NFLT-1:0] flt;
      logic [EFS_NFLT-1:0] sel_maj;
      logic [EFS_NFLT-1:0] sel_min;
      logic [12:0] dly;
      logic [12:0] tdev_dly;
      logic [7:0] addr_a;
      logic [7:0] addr_b;
      logic reset_all;
      logic reset_all_d;
      logic crank_above_d;
      logic [17:0] tick_cnt;
      logic [12:0] cnt_rem;
      logic [12:0] cnt_trq;
      logic [12:0] cnt_dev;
      logic [23:0] flash_cnt;
      logic wd_lock;
      logic [31:0] rdata;
      logic [5:0] outs;
   } efs_state_s;

   efs_state_s st_r;
   efs_state_s st_nxt;

   logic tick;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic reset_ev;
   logic crank_above;
   logic [EFS_NFLT-1:0] cause;
   logic rem_bad;
   logic trq_bad;
   logic [EFS_SPD_W+6:0] spd_scaled;
   logic [EFS_SPD_W+6:0] rated_scaled;
   logic [12:0] dly_eff;
   logic [12:0] tdev_eff;
   logic addr_err;

   assign PREADY = 1'b1;
   assign wr_en = PSEL && PENABLE && PWRITE;
   // read data is captured in the setup cycle so it stands through the access phase
   assign rd_en = PSEL && !PENABLE && !PWRITE;
   assign tick = (st_r.tick_cnt == EFS_TICK_LAST);

   // crank threshold: speed*100 > rated*5, no divider needed
   assign spd_scaled = (EFS_SPD_W+7)'(SPEED_A) * (EFS_SPD_W+7)'(100);
   assign rated_scaled = (EFS_SPD_W+7)'(RATED_SPEED) * (EFS_SPD_W+7)'(EFS_CRANK_PCT);
   assign crank_above = CRANKING && (spd_scaled > rated_scaled);
   assign reset_ev = (crank_above && !st_r.crank_above_d)
      || (st_r.reset_all && !st_r.reset_all_d);

   assign rem_bad = (REMOTE_MA < EFS_MA_LO) || (REMOTE_MA > EFS_MA_HI);
   assign trq_bad = (TORQUE_MA < EFS_MA_LO) || (TORQUE_MA > EFS_MA_HI);

   // clamp so a zero delay still means one tick
   assign dly_eff = (st_r.dly < EFS_DLY_MIN) ? EFS_DLY_MIN :
      (st_r.dly > EFS_DLY_MAX) ? EFS_DLY_MAX : st_r.dly;
   assign tdev_eff = (st_r.tdev_dly < EFS_DLY_MIN) ? EFS_DLY_MIN : st_r.tdev_dly;

   // ----------------------------------------
   // fault causes
   // ----------------------------------------
   always_comb begin
      cause = '0;
      cause[EFS_F_SENS_A] = RUN_MODE && !STOP_MODE && (SPEED_A < FAILSAFE_SPEED);
      cause[EFS_F_SENS_B] = RUN_MODE && !STOP_MODE && (SPEED_B < FAILSAFE_SPEED);
      cause[EFS_F_OVSPD] = (SPEED_A > OVERSPEED_SETPOINT)
         || (SPEED_B > OVERSPEED_SETPOINT);
      cause[EFS_F_REMOTE] = rem_bad && (st_r.cnt_rem >= dly_eff);
      cause[EFS_F_TORQUE] = trq_bad && (st_r.cnt_trq >= dly_eff);
      cause[EFS_F_TDEV] = TORQUE_DEV_EXCEEDED && (st_r.cnt_dev >= tdev_eff);
   end

   assign addr_err = (st_r.addr_a != st_r.addr_b) || (st_r.addr_a == 8'h00)
      || (st_r.addr_b == 8'h00);

   assign addr_ok = (PADDR == EFS_CTRL_OFS) || (PADDR == EFS_DLY_OFS)
      || (PADDR == EFS_MAJ_OFS) || (PADDR == EFS_MIN_OFS)
      || (PADDR == EFS_ADDR_OFS) || (PADDR == EFS_STAT_OFS)
      || (PADDR == EFS_TDEV_OFS);
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [EFS_NFLT-1:0] f;
      logic lock;
      st_nxt = st_r;
      f = st_r.flt;
      lock = 1'b0;
      st_nxt.tick_cnt = tick ? 18'h00000 : st_r.tick_cnt + 18'h00001;
      st_nxt.flash_cnt = st_r.flash_cnt + 24'h000001;
      // filters restart on any clean sample so the delay is continuous
      if (!rem_bad) begin
         st_nxt.cnt_rem = 13'h0000;
      end else if (tick && st_r.cnt_rem != EFS_DLY_MAX) begin
         st_nxt.cnt_rem = st_r.cnt_rem + 13'h0001;
      end
      if (!trq_bad) begin
         st_nxt.cnt_trq = 13'h0000;
      end else if (tick && st_r.cnt_trq != EFS_DLY_MAX) begin
         st_nxt.cnt_trq = st_r.cnt_trq + 13'h0001;
      end
      if (!TORQUE_DEV_EXCEEDED) begin
         st_nxt.cnt_dev = 13'h0000;
      end else if (tick && st_r.cnt_dev != 13'h1fff) begin
         st_nxt.cnt_dev = st_r.cnt_dev + 13'h0001;
      end
      st_nxt.crank_above_d = crank_above;
      st_nxt.reset_all_d = st_r.reset_all;
      // reset clears only latches whose cause is gone; new causes win
      if (reset_ev) begin
         f = f & cause;
      end
      f = f | cause;
      if (STOP_MODE) begin
         f[EFS_F_SENS_A] = 1'b0;
         f[EFS_F_SENS_B] = 1'b0;
      end
      st_nxt.flt = f;
      // watchdog lock holds until reset; only power-up leaves it
      if (WATCHDOG_TIMEOUT) begin
         st_nxt.wd_lock = 1'b1;
      end
      lock = st_nxt.wd_lock;
      st_nxt.outs[0] = !lock && ((f[EFS_F_SENS_A] && f[EFS_F_SENS_B])
         || f[EFS_F_OVSPD]);
      st_nxt.outs[1] = !lock && (f[EFS_F_SENS_A] ^ f[EFS_F_SENS_B]);
      st_nxt.outs[2] = !lock && !(f[EFS_F_SENS_A] ^ f[EFS_F_SENS_B]);
      st_nxt.outs[3] = !lock && (f[EFS_F_TORQUE] || f[EFS_F_TDEV]);
      st_nxt.outs[4] = !lock && |(f & st_r.sel_maj);
      st_nxt.outs[5] = !lock && |(f & st_r.sel_min);
      // apb writes
      if (wr_en) begin
         if (PADDR == EFS_CTRL_OFS) begin
            st_nxt.reset_all = PWDATA[EFS_CTRL_RESET_ALL];
         end else if (PADDR == EFS_DLY_OFS) begin
            st_nxt.dly = PWDATA[12:0];
         end else if (PADDR == EFS_MAJ_OFS) begin
            st_nxt.sel_maj = PWDATA[EFS_NFLT-1:0];
         end else if (PADDR == EFS_MIN_OFS) begin
            st_nxt.sel_min = PWDATA[EFS_NFLT-1:0];
         end else if (PADDR == EFS_ADDR_OFS) begin
            st_nxt.addr_a = PWDATA[7:0];
            st_nxt.addr_b = PWDATA[15:8];
         end else if (PADDR == EFS_TDEV_OFS) begin
            st_nxt.tdev_dly = PWDATA[12:0];
         end
      end
      st_nxt.rdata = 32'h00000000;
      if (rd_en) begin
         if (PADDR == EFS_CTRL_OFS) begin
            st_nxt.rdata = {31'h00000000, st_r.reset_all};
         end else if (PADDR == EFS_DLY_OFS) begin
            st_nxt.rdata = {19'h00000, st_r.dly};
         end else if (PADDR == EFS_MAJ_OFS) begin
            st_nxt.rdata = {26'h0000000, st_r.sel_maj};
         end else if (PADDR == EFS_MIN_OFS) begin
            st_nxt.rdata = {26'h0000000, st_r.sel_min};
         end else if (PADDR == EFS_ADDR_OFS) begin
            st_nxt.rdata = {16'h0000, st_r.addr_b, st_r.addr_a};
         end else if (PADDR == EFS_STAT_OFS) begin
            st_nxt.rdata = {22'h000000, addr_err, COMM_FAULT_A && COMM_FAULT_B,
               st_r.wd_lock, st_r.outs[3], st_r.flt};
         end else if (PADDR == EFS_TDEV_OFS) begin
            st_nxt.rdata = {19'h00000, st_r.tdev_dly};
         end
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st_r <= '{flt: '0, sel_maj: EFS_SEL_RST, sel_min: EFS_SEL_RST,
            dly: EFS_DLY_RST, tdev_dly: EFS_TDEV_RST, addr_a: 8'h00, addr_b: 8'h00,
            reset_all: 1'b0, reset_all_d: 1'b0, crank_above_d: 1'b0,
            tick_cnt: 18'h00000, cnt_rem: 13'h0000, cnt_trq: 13'h0000,
            cnt_dev: 13'h0000, flash_cnt: 24'h000000, wd_lock: 1'b0,
            rdata: 32'h00000000, outs: 6'h04};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign PRDATA = st_r.rdata;
   assign MIN_FUEL = st_r.outs[0];
   assign HIGH_SELECT = st_r.outs[1];
   assign COUPLING_FILTER_EN = st_r.outs[2];
   assign LOAD_SRC_BACKUP = st_r.outs[3];
   assign MAJOR_ALARM = st_r.outs[4];
   assign MINOR_ALARM = st_r.outs[5];
   assign OUTPUT_LOCK = st_r.wd_lock;
   assign PROCESSOR_HEALTHY_INDICATOR = !st_r.wd_lock;
   assign SUPPLY_GOOD_INDICATOR = SUPPLY_GOOD && !st_r.wd_lock;
   assign SENSOR_A_FAILED_INDICATOR = st_r.flt[EFS_F_SENS_A] && !st_r.wd_lock;
   assign SENSOR_B_FAILED_INDICATOR = st_r.flt[EFS_F_SENS_B] && !st_r.wd_lock;
   // flashes at about 1 hz from bit 23 of the free counter
   assign ADDRESS_ERROR_INDICATOR = addr_err && st_r.flash_cnt[23] && !st_r.wd_lock;
   assign COMM_ERROR_INDICATOR = COMM_FAULT_A && COMM_FAULT_B && !st_r.wd_lock;
   assign OVERSPEED_LATCHED_FLAG = st_r.flt[EFS_F_OVSPD];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_sens_latch: assert property (@(posedge MCLK) disable iff (RST)
      cause[EFS_F_SENS_A] && !STOP_MODE |=> st_r.flt[EFS_F_SENS_A])
      else $error("sensor a fault did not latch");
   a_stop_clear: assert property (@(posedge MCLK) disable iff (RST)
      STOP_MODE |=> !st_r.flt[EFS_F_SENS_A] && !st_r.flt[EFS_F_SENS_B])
      else $error("sensor fault set in stop mode");
   a_latch_hold: assert property (@(posedge MCLK) disable iff (RST)
      st_r.flt[EFS_F_OVSPD] && !reset_ev |=> st_r.flt[EFS_F_OVSPD])
      else $error("overspeed latch dropped without reset");
   a_reset_spare: assert property (@(posedge MCLK) disable iff (RST)
      reset_ev && cause[EFS_F_OVSPD] |=> st_r.flt[EFS_F_OVSPD])
      else $error("reset cleared active fault");
   a_minfuel_ovs: assert property (@(posedge MCLK) disable iff (RST)
      st_r.flt[EFS_F_OVSPD] && !st_r.wd_lock |-> MIN_FUEL)
      else $error("overspeed without minimum fuel");
   a_wd_lock: assert property (@(posedge MCLK) disable iff (RST)
      WATCHDOG_TIMEOUT |=> OUTPUT_LOCK && !PROCESSOR_HEALTHY_INDICATOR && !MAJOR_ALARM)
      else $error("watchdog did not lock outputs");
   a_rall_edge: assert property (@(posedge MCLK) disable iff (RST)
      st_r.reset_all && st_r.reset_all_d && !crank_above |-> !reset_ev)
      else $error("held reset-all retriggered");
   a_ana_delay: assert property (@(posedge MCLK) disable iff (RST)
      !rem_bad ##1 rem_bad |-> !cause[EFS_F_REMOTE])
      else $error("remote fault without delay");
   a_comm_err: assert property (@(posedge MCLK) disable iff (RST)
      COMM_ERROR_INDICATOR |-> COMM_FAULT_A && COMM_FAULT_B)
      else $error("comm error with one channel good");
   a_sens_b_latch: assert property (@(posedge MCLK) disable iff (RST)
      cause[EFS_F_SENS_B] |=> st_r.flt[EFS_F_SENS_B])
      else $error("sensor b fault did not latch");
   a_sens_hold: assert property (@(posedge MCLK) disable iff (RST)
      st_r.flt[EFS_F_SENS_A] && !reset_ev && !STOP_MODE |=> st_r.flt[EFS_F_SENS_A])
      else $error("sensor a latch dropped without reset");
   a_ovs_latch: assert property (@(posedge MCLK) disable iff (RST)
      cause[EFS_F_OVSPD] |=> OVERSPEED_LATCHED_FLAG)
      else $error("overspeed did not latch");
   a_both_minfuel: assert property (@(posedge MCLK) disable iff (RST)
      st_r.flt[EFS_F_SENS_A] && st_r.flt[EFS_F_SENS_B] && !st_r.wd_lock |-> MIN_FUEL)
      else $error("both sensors failed without minimum fuel");
   a_sens_ind: assert property (@(posedge MCLK) disable iff (RST)
      !st_r.wd_lock |-> (SENSOR_A_FAILED_INDICATOR == st_r.flt[EFS_F_SENS_A])
         && (SENSOR_B_FAILED_INDICATOR == st_r.flt[EFS_F_SENS_B]))
      else $error("sensor indicator differs from latch");
   a_single_hsel: assert property (@(posedge MCLK) disable iff (RST)
      (st_r.flt[EFS_F_SENS_A] ^ st_r.flt[EFS_F_SENS_B]) && !st_r.wd_lock
         |-> HIGH_SELECT && !COUPLING_FILTER_EN)
      else $error("single sensor fault without high select");
   a_dual_filter: assert property (@(posedge MCLK) disable iff (RST)
      !(st_r.flt[EFS_F_SENS_A] ^ st_r.flt[EFS_F_SENS_B]) && !st_r.wd_lock
         |-> COUPLING_FILTER_EN && !HIGH_SELECT)
      else $error("filter off without single sensor fault");
   a_lock_hold: assert property (@(posedge MCLK) disable iff (RST)
      OUTPUT_LOCK |=> OUTPUT_LOCK)
      else $error("output lock released without reset");
   a_lock_quiet: assert property (@(posedge MCLK) disable iff (RST)
      OUTPUT_LOCK |-> !MIN_FUEL && !HIGH_SELECT && !COUPLING_FILTER_EN
         && !LOAD_SRC_BACKUP && !MAJOR_ALARM && !MINOR_ALARM)
      else $error("discrete output active under lock");
   a_trq_delay: assert property (@(posedge MCLK) disable iff (RST)
      !trq_bad ##1 trq_bad |-> !cause[EFS_F_TORQUE])
      else $error("torque fault without delay");
   a_trq_backup: assert property (@(posedge MCLK) disable iff (RST)
      st_r.flt[EFS_F_TORQUE] && !st_r.wd_lock |-> LOAD_SRC_BACKUP)
      else $error("torque fault without backup load source");
   a_dev_clear: assert property (@(posedge MCLK) disable iff (RST)
      reset_ev && !cause[EFS_F_TDEV] |=> !st_r.flt[EFS_F_TDEV])
      else $error("reset kept torque deviation backup");
   a_addr_flash: assert property (@(posedge MCLK) disable iff (RST)
      ADDRESS_ERROR_INDICATOR |-> addr_err)
      else $error("address indicator without address error");
endmodule : efs_supervisor

// file: dv/efs_plant.sv
`timescale 1ns/10ps
module efs_plant (
   input wire logic clk,
   input wire logic [efs_pkg::EFS_SPD_W-1:0] rpm,
   input wire logic drop_a,
   input wire logic drop_b,
   output logic [efs_pkg::EFS_SPD_W-1:0] spd_a,
   output logic [efs_pkg::EFS_SPD_W-1:0] spd_b
);
   import efs_pkg::*;
   // ----------------------------------------
   // magnetic pickups
   // ----------------------------------------
   // a dropped pickup gives no pulses, so its measured speed reads zero
   always_ff @(posedge clk) begin
      spd_a <= drop_a ? '0 : rpm;
      spd_b <= drop_b ? '0 : rpm;
   end
endmodule : efs_plant

// file: dv/engine_fault_supervisor_bench.sv
`timescale 1ns/10ps
module engine_fault_supervisor_bench;
   import efs_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, rem, tq;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] rpm, spd_a, spd_b, fs, osp, rated;
   logic drop_a, drop_b, run, stop, crank, tdev, wdt, sgood, ca, cb;
   logic min_fuel, hsel, cfe, lbk, lock, phi, sgi, sai, sbi, aei, cei, ovf, maj, mnr;
   logic [7:0] ada [4] = '{8'h05, 8'h05, 8'h00, 8'h07};
   logic [7:0] adb [4] = '{8'h05, 8'h06, 8'h00, 8'h00};
   int err_total = 0, tests_run = 0, majsel = 0, minsel = 0;
   int lt [3] = '{0, 0, 0};
   efs_plant plant (.clk(mclk), .rpm(rpm), .drop_a(drop_a), .drop_b(drop_b),
      .spd_a(spd_a), .spd_b(spd_b));
   efs_supervisor dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SPEED_A(spd_a), .SPEED_B(spd_b), .FAILSAFE_SPEED(fs),
      .OVERSPEED_SETPOINT(osp), .RATED_SPEED(rated), .RUN_MODE(run), .STOP_MODE(stop),
      .CRANKING(crank), .REMOTE_MA(rem), .TORQUE_MA(tq), .TORQUE_DEV_EXCEEDED(tdev),
      .WATCHDOG_TIMEOUT(wdt), .SUPPLY_GOOD(sgood), .COMM_FAULT_A(ca), .COMM_FAULT_B(cb),
      .MIN_FUEL(min_fuel), .HIGH_SELECT(hsel), .COUPLING_FILTER_EN(cfe),
      .LOAD_SRC_BACKUP(lbk), .OUTPUT_LOCK(lock), .PROCESSOR_HEALTHY_INDICATOR(phi),
      .SUPPLY_GOOD_INDICATOR(sgi), .SENSOR_A_FAILED_INDICATOR(sai),
      .SENSOR_B_FAILED_INDICATOR(sbi), .ADDRESS_ERROR_INDICATOR(aei),
      .COMM_ERROR_INDICATOR(cei), .OVERSPEED_LATCHED_FLAG(ovf), .MAJOR_ALARM(maj),
      .MINOR_ALARM(mnr));
   // ----------------------------------------
   // reference model
   // ----------------------------------------
   function automatic bit cause(int i);
      int s;
      s = (i == 0 ? drop_a : drop_b) ? 0 : int'(rpm);
      if (i == 2) return (!drop_a || !drop_b) && int'(rpm) > int'(osp);
      return run && !stop && s < int'(fs);
   endfunction : cause
   task automatic step();
      for (int i = 0; i < 3; i++) lt[i] = (i < 2 && stop) ? 0 : (lt[i] | cause(i));
   endtask : step
   // a reset event spares any latch whose cause still stands
   task automatic revt();
      for (int i = 0; i < 3; i++) lt[i] = lt[i] & cause(i);
   endtask : revt
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic settle();
      int v;
      repeat (4) @(posedge mclk);
      step();
      v = lt[0] | (lt[1] << 1) | (lt[2] << 2);
      @(negedge mclk);
      check(sai, lt[0]);
      check(sbi, lt[1]);
      check(ovf, lt[2]);
      check(min_fuel, (lt[0] && lt[1]) || lt[2]);
      check(maj, (majsel & v) != 0);
      check(mnr, (minsel & v) != 0);
      if (lt[0] != lt[1]) begin
         check({hsel, cfe}, 2'b10);
      end else if (lt[0] == 0) begin
         check({hsel, cfe}, 2'b01);
      end
   endtask : settle
   // ----------------------------------------
   // apb master
   // ----------------------------------------
   task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // response and read data are taken at the edge where pready is seen high
      do @(posedge mclk); while (pready !== 1'b1);
      e = pslverr;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      conclude();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {drop_a, drop_b, run, stop, crank, tdev, wdt, ca, cb, sgood} = 10'h001;
      {rem, tq} = 16'h6464;
      void'($urandom(14));
      fs = 16'(200 + $urandom % 100);
      osp = 16'(1500 + $urandom % 200);
      rpm = 16'(600 + $urandom % 300);
      rated = 16'h03e8;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check({phi, sgi, cfe, min_fuel}, 4'he);
      apb(0, EFS_MAJ_OFS, 0); check(q, 0);
      apb(0, EFS_MIN_OFS, 0); check(q, 0);
      apb(0, EFS_DLY_OFS, 0); check(q, 32'(EFS_DLY_RST));
      apb(0, 8'h20, 0); check(q, 0);
      check(32'(e), 1);
      for (int i = 0; i < 4; i++) begin
         apb(1, EFS_ADDR_OFS, {16'h0000, adb[i], ada[i]});
         apb(0, EFS_STAT_OFS, 0);
         check(q[9], ada[i] == 0 || adb[i] == 0 || ada[i] != adb[i]);
         if (i == 0) check(aei, 0);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         ca <= i[0];
         cb <= i[1];
         @(negedge mclk); check(cei, i[0] & i[1]);
      end
      majsel = 5;
      minsel = 2;
      apb(1, EFS_MAJ_OFS, 32'h5);
      apb(1, EFS_MIN_OFS, 32'h2);
      @(posedge mclk);
      run <= 1'b1;
      settle();
      // one-cycle dropout must latch at once
      @(posedge mclk);
      drop_a <= 1'b1;
      @(posedge mclk);
      step();
      drop_a <= 1'b0;
      settle();
      @(posedge mclk);
      drop_b <= 1'b1;
      settle();
      apb(1, EFS_CTRL_OFS, 32'h1); revt(); settle();
      @(posedge mclk);
      drop_b <= 1'b0;
      apb(1, EFS_CTRL_OFS, 32'h1); settle();
      apb(1, EFS_CTRL_OFS, 32'h0);
      apb(1, EFS_CTRL_OFS, 32'h1); revt(); settle();
      @(posedge mclk);
      stop <= 1'b1;
      drop_a <= 1'b1;
      settle();
      @(posedge mclk);
      drop_a <= 1'b0;
      @(posedge mclk);
      stop <= 1'b0;
      @(posedge mclk);
      rpm <= osp + 16'h0001;
      settle();
      @(posedge mclk);
      // speed starts from rest, then rises past the crank threshold
      {run, crank, rpm} <= {2'b01, 16'h0000};
      repeat (3) @(posedge mclk);
      rpm <= 16'h0064;
      @(posedge mclk); revt(); settle();
      // short excursions stay well inside one filter tick
      @(posedge mclk);
      {rem, tq, tdev} <= {16'h05f0, 1'b1};
      repeat (200) @(posedge mclk);
      apb(0, EFS_STAT_OFS, 0); check(q[6:0], 7'h00);
      check(lbk, 0);
      @(posedge mclk);
      {rem, tq, tdev, crank, rpm} <= {16'h6464, 2'b00, osp + 16'h0001};
      settle();
      @(posedge mclk);
      wdt <= 1'b1;
      @(posedge mclk);
      wdt <= 1'b0;
      repeat (24) @(posedge mclk);
      @(negedge mclk);
      check({lock, phi, sgi, min_fuel, maj, ovf}, 6'h21);
      // only a full reset leaves the watchdog lock
      @(posedge mclk);
      {rst, rpm} <= {1'b1, 16'h0064};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check({lock, phi, ovf, sgi}, 4'h5);
      conclude();
   end
endmodule : engine_fault_supervisor_bench
